/* rtl/scm_clock_mode.sv */
// system clock source, gear, clock output, warm-up, halt and protection control
// ******************************************************
// ******************************************************
`timescale 1ns/100ps
module scm_clock_mode
	import scm_pkg::*;
#(
	parameter int WU_CYC_14 = WU_CNT_14,
	parameter int WU_CYC_16 = WU_CNT_16
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [9:0] avs_address,
	input  wire logic       avs_read,
	input  wire logic       avs_write,
	input  wire logic [7:0] avs_writedata,
	output logic      [7:0] avs_readdata,
	output logic            avs_waitrequest,
	input  wire logic       low_freq_clock,
	input  wire logic       warmup_start,
	input  wire logic       halt_req,
	input  wire logic       wake_req,
	output logic            cpu_clk_en,
	output logic            periph_clk_en,
	output logic            clock_output_pin,
	output logic            warmup_busy,
	output logic            halt_pins_off,
	output logic            halt_pins_hold,
	output logic      [1:0] halt_mode,
	output logic            latch_strobe_output_enable,
	output logic            external_clock_input_select,
	output logic            high_osc_drive_strength,
	output logic            low_osc_drive_strength
);

	// ******************************************************
	// registers and bus slave
	// ******************************************************
	logic       src_sel_ff,   nxt_src_sel;
	logic [2:0] gear_ff,      nxt_gear;
	logic       out_sel_ff,   nxt_out_sel;
	logic [1:0] warmup_ff,    nxt_warmup;
	logic [1:0] halt_type_ff, nxt_halt_type;
	logic       pin_hold_ff,  nxt_pin_hold;
	logic [6:0] noise_ff,     nxt_noise;
	logic       protect_ff,   nxt_protect;
	logic [3:0] dbl_ctrl_ff,  nxt_dbl_ctrl;
	logic [7:0] dbl_set_ff,   nxt_dbl_set;
	logic       wait_ff,      nxt_wait;
	logic [7:0] rdata_ff,     nxt_rdata;
	logic       wr_take;

	assign wr_take = avs_write && !wait_ff;

	always_comb begin
		nxt_src_sel   = src_sel_ff;
		nxt_gear      = gear_ff;
		nxt_out_sel   = out_sel_ff;
		nxt_warmup    = warmup_ff;
		nxt_halt_type = halt_type_ff;
		nxt_pin_hold  = pin_hold_ff;
		nxt_noise     = noise_ff;
		nxt_protect   = protect_ff;
		nxt_dbl_ctrl  = dbl_ctrl_ff;
		nxt_dbl_set   = dbl_set_ff;
		nxt_rdata     = rdata_ff;
		// one wait state per access, then release for a single cycle
		nxt_wait      = !(wait_ff && (avs_read || avs_write));
		if (avs_read && wait_ff) begin
			// undefined bits return zero
			unique case (avs_address)
				ADDR_SRC_GEAR: nxt_rdata = {4'h0, src_sel_ff, gear_ff};
				ADDR_OUT_HALT: nxt_rdata = {1'b0, out_sel_ff, warmup_ff, halt_type_ff,
				                            1'b0, pin_hold_ff};
				ADDR_NOISE:    nxt_rdata = {protect_ff, noise_ff};
				ADDR_DBL_CTRL: nxt_rdata = {dbl_ctrl_ff, 4'h0};
				ADDR_DBL_SET:  nxt_rdata = dbl_set_ff;
				default:       nxt_rdata = 8'h00;
			endcase
		end
		if (wr_take && avs_address == ADDR_PROTECT) begin
			nxt_protect = (avs_writedata != PROTECT_OFF);
		end else if (wr_take && !protect_ff) begin
			// protection blocks every other register while on
			unique case (avs_address)
				ADDR_SRC_GEAR: begin
					nxt_src_sel = avs_writedata[BIT_SRC_SEL];
					nxt_gear    = avs_writedata[2:0];
				end
				ADDR_OUT_HALT: begin
					nxt_out_sel   = avs_writedata[BIT_OUT_SEL];
					nxt_warmup    = avs_writedata[5:4];
					nxt_halt_type = avs_writedata[3:2];
					nxt_pin_hold  = avs_writedata[BIT_PIN_HOLD];
				end
				ADDR_NOISE:    nxt_noise    = avs_writedata[6:0];
				ADDR_DBL_CTRL: nxt_dbl_ctrl = avs_writedata[7:4];
				ADDR_DBL_SET:  nxt_dbl_set  = avs_writedata;
				default:       nxt_noise    = noise_ff;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			src_sel_ff   <= RST_SRC_SEL;
			gear_ff      <= RST_GEAR;
			out_sel_ff   <= RST_OUT_SEL;
			warmup_ff    <= RST_WARMUP;
			halt_type_ff <= RST_HALT_TYPE;
			pin_hold_ff  <= RST_PIN_HOLD;
			noise_ff     <= RST_NOISE;
			protect_ff   <= 1'b0;
			dbl_ctrl_ff  <= RST_DBL_CTRL;
			dbl_set_ff   <= RST_DBL_SET;
			wait_ff      <= 1'b1;
			rdata_ff     <= 8'h00;
		end else begin
			src_sel_ff   <= nxt_src_sel;
			gear_ff      <= nxt_gear;
			out_sel_ff   <= nxt_out_sel;
			warmup_ff    <= nxt_warmup;
			halt_type_ff <= nxt_halt_type;
			pin_hold_ff  <= nxt_pin_hold;
			noise_ff     <= nxt_noise;
			protect_ff   <= nxt_protect;
			dbl_ctrl_ff  <= nxt_dbl_ctrl;
			dbl_set_ff   <= nxt_dbl_set;
			wait_ff      <= nxt_wait;
			rdata_ff     <= nxt_rdata;
		end
	end

	// ******************************************************
	// clock source, gear and clock output
	// ******************************************************
	logic       gear_tick;
	logic       lf_s1_ff, lf_s2_ff, lf_s3_ff;
	logic       lf_lvl_ff, nxt_lf_lvl;
	logic       lf_tick_ff, nxt_lf_tick;
	logic       cur_src_ff, nxt_cur_src;
	logic       sel_tick;
	logic       out_tick;
	logic       clk_out_ff, nxt_clk_out;
	logic       cpu_en_ff, nxt_cpu_en;
	logic       per_en_ff, nxt_per_en;
	scm_state_t state_ff, nxt_state;

	scm_gear_div u_gear (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.gear_code (gear_ff),
		.gear_tick (gear_tick)
	);

	assign sel_tick = cur_src_ff ? lf_tick_ff : gear_tick;
	assign out_tick = out_sel_ff ? gear_tick : lf_tick_ff;

	always_comb begin
		// a pin change only counts once the last two stages agree
		nxt_lf_lvl  = (lf_s2_ff == lf_s3_ff) ? lf_s3_ff : lf_lvl_ff;
		nxt_lf_tick = nxt_lf_lvl && !lf_lvl_ff;
		// switch source on a tick of the old one: no runt clock
		nxt_cur_src = sel_tick ? src_sel_ff : cur_src_ff;
		// output pin frozen in stop, it has no clock to show
		nxt_clk_out = (out_tick && state_ff != SCM_STOP) ? !clk_out_ff : clk_out_ff;
		nxt_cpu_en  = sel_tick && state_ff == SCM_RUN;
		nxt_per_en  = sel_tick && (state_ff == SCM_RUN || state_ff == SCM_FULL);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lf_s1_ff   <= 1'b0;
			lf_s2_ff   <= 1'b0;
			lf_s3_ff   <= 1'b0;
			lf_lvl_ff  <= 1'b0;
			lf_tick_ff <= 1'b0;
			cur_src_ff <= RST_SRC_SEL;
			clk_out_ff <= 1'b0;
			cpu_en_ff  <= 1'b0;
			per_en_ff  <= 1'b0;
		end else begin
			lf_s1_ff   <= low_freq_clock;
			lf_s2_ff   <= lf_s1_ff;
			lf_s3_ff   <= lf_s2_ff;
			lf_lvl_ff  <= nxt_lf_lvl;
			lf_tick_ff <= nxt_lf_tick;
			cur_src_ff <= nxt_cur_src;
			clk_out_ff <= nxt_clk_out;
			cpu_en_ff  <= nxt_cpu_en;
			per_en_ff  <= nxt_per_en;
		end
	end

	// ******************************************************
	// warm-up timer and halt control
	// ******************************************************
	logic [16:0] wu_cnt_ff, nxt_wu_cnt;
	logic        wu_busy_ff, nxt_wu_busy;
	logic        pins_off_ff, nxt_pins_off;
	logic        pins_hold_ff, nxt_pins_hold;
	logic        stop_like;

	function automatic logic [16:0] wu_length(input logic [1:0] code);
		unique case (code)
			WU_CODE_8:  wu_length = WU_CNT_8;
			WU_CODE_14: wu_length = 17'(WU_CYC_14);
			WU_CODE_16: wu_length = 17'(WU_CYC_16);
			default:    wu_length = 17'(WU_CYC_14);
		endcase
	endfunction

	assign stop_like = (state_ff == SCM_STOP) || (state_ff == SCM_LIGHT);

	always_comb begin
		nxt_wu_cnt  = wu_cnt_ff;
		nxt_wu_busy = wu_busy_ff;
		// a start while counting is ignored, the running count stands
		if (warmup_start && !wu_busy_ff) begin
			nxt_wu_busy = 1'b1;
			nxt_wu_cnt  = 17'(wu_length(warmup_ff) - 17'h1);
		end else if (wu_busy_ff) begin
			if (wu_cnt_ff == 17'h0) begin
				nxt_wu_busy = 1'b0;
			end else begin
				nxt_wu_cnt = wu_cnt_ff - 17'h1;
			end
		end
		nxt_state = state_ff;
		unique case (state_ff)
			SCM_RUN: begin
				if (halt_req) begin
					unique case (halt_type_ff)
						HALT_STOP:  nxt_state = SCM_STOP;
						HALT_LIGHT: nxt_state = SCM_LIGHT;
						HALT_FULL:  nxt_state = SCM_FULL;
						default:    nxt_state = SCM_RUN;
					endcase
				end
			end
			SCM_STOP, SCM_LIGHT, SCM_FULL: begin
				if (wake_req) begin
					nxt_state = SCM_RUN;
				end
			end
			default: nxt_state = SCM_RUN;
		endcase
		nxt_pins_off  = stop_like && !pin_hold_ff;
		nxt_pins_hold = stop_like && pin_hold_ff;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wu_cnt_ff    <= 17'h0;
			wu_busy_ff   <= 1'b0;
			state_ff     <= SCM_RUN;
			pins_off_ff  <= 1'b0;
			pins_hold_ff <= 1'b0;
		end else begin
			wu_cnt_ff    <= nxt_wu_cnt;
			wu_busy_ff   <= nxt_wu_busy;
			state_ff     <= nxt_state;
			pins_off_ff  <= nxt_pins_off;
			pins_hold_ff <= nxt_pins_hold;
		end
	end

	assign avs_readdata                = rdata_ff;
	assign avs_waitrequest             = wait_ff;
	assign cpu_clk_en                  = cpu_en_ff;
	assign periph_clk_en               = per_en_ff;
	assign clock_output_pin            = clk_out_ff;
	assign warmup_busy                 = wu_busy_ff;
	assign halt_pins_off               = pins_off_ff;
	assign halt_pins_hold              = pins_hold_ff;
	assign halt_mode                   = halt_type_ff;
	assign latch_strobe_output_enable  = noise_ff[NZ_LATCH_EN];
	assign external_clock_input_select = noise_ff[NZ_EXT_CLK];
	assign high_osc_drive_strength     = noise_ff[NZ_DRV_HIGH];
	assign low_osc_drive_strength      = noise_ff[NZ_DRV_LOW];

	// ******************************************************
	// assertions
	// ******************************************************
	property p_cpu_src;
		@(posedge sys_clk) disable iff (rst)
		cpu_en_ff |-> $past(cur_src_ff ? lf_tick_ff : gear_tick);
	endproperty
	a_cpu_src: assert property (p_cpu_src) else $error("cpu enable not from selected source");

	property p_clkout;
		@(posedge sys_clk) disable iff (rst)
		$changed(clk_out_ff) |-> $past(out_sel_ff ? gear_tick : lf_tick_ff);
	endproperty
	a_clkout: assert property (p_clkout) else $error("clock output toggled off its tick");

	property p_warmup;
		@(posedge sys_clk) disable iff (rst)
		(warmup_start && !wu_busy_ff && warmup_ff == WU_CODE_8)
			|=> wu_busy_ff ##255 wu_busy_ff ##1 !wu_busy_ff;
	endproperty
	a_warmup: assert property (p_warmup) else $error("short warm-up length wrong");

	property p_halt_stop;
		@(posedge sys_clk) disable iff (rst)
		(state_ff == SCM_RUN && halt_req && halt_type_ff == HALT_STOP) |=> state_ff == SCM_STOP;
	endproperty
	a_halt_stop: assert property (p_halt_stop) else $error("stop not entered");

	property p_pins;
		@(posedge sys_clk) disable iff (rst)
		pins_off_ff |-> $past(stop_like && !pin_hold_ff) && !pins_hold_ff;
	endproperty
	a_pins: assert property (p_pins) else $error("pins off without cause");

	property p_prot_on;
		@(posedge sys_clk) disable iff (rst)
		(wr_take && avs_address == ADDR_PROTECT && avs_writedata != PROTECT_OFF) |=> protect_ff;
	endproperty
	a_prot_on: assert property (p_prot_on) else $error("protection not turned on");

	property p_prot_off;
		@(posedge sys_clk) disable iff (rst)
		(wr_take && avs_address == ADDR_PROTECT && avs_writedata == PROTECT_OFF) |=> !protect_ff;
	endproperty
	a_prot_off: assert property (p_prot_off) else $error("protection not turned off");

	property p_prot_block;
		@(posedge sys_clk) disable iff (rst)
		(protect_ff && wr_take && avs_address == ADDR_SRC_GEAR) |=> $stable(gear_ff);
	endproperty
	a_prot_block: assert property (p_prot_block) else $error("protected write landed");

	property p_src_edge;
		@(posedge sys_clk) disable iff (rst)
		$changed(cur_src_ff) |-> $past(sel_tick);
	endproperty
	a_src_edge: assert property (p_src_edge) else $error("source switched off boundary");

endmodule // scm_clock_mode

/* pkg/scm_pkg.sv */
// shared constants for the system clock mode control block
package scm_pkg;

	// ******************************************************
	// register indices and byte addresses
	// ******************************************************
	localparam logic [7:0] IDX_SRC_GEAR   = 8'hE1;
	localparam logic [7:0] IDX_OUT_HALT   = 8'hE2;
	localparam logic [7:0] IDX_NOISE      = 8'hE3;
	localparam logic [7:0] IDX_PROTECT    = 8'hE4;
	localparam logic [7:0] IDX_DBL_CTRL   = 8'hE8;
	localparam logic [7:0] IDX_DBL_SET    = 8'hE9;
	localparam logic [9:0] ADDR_SRC_GEAR  = {IDX_SRC_GEAR, 2'h0};
	localparam logic [9:0] ADDR_OUT_HALT  = {IDX_OUT_HALT, 2'h0};
	localparam logic [9:0] ADDR_NOISE     = {IDX_NOISE, 2'h0};
	localparam logic [9:0] ADDR_PROTECT   = {IDX_PROTECT, 2'h0};
	localparam logic [9:0] ADDR_DBL_CTRL  = {IDX_DBL_CTRL, 2'h0};
	localparam logic [9:0] ADDR_DBL_SET   = {IDX_DBL_SET, 2'h0};

	// ******************************************************
	// reset values and fields
	// ******************************************************
	localparam logic       RST_SRC_SEL    = 1'h0;
	localparam logic [2:0] RST_GEAR       = 3'h4;
	localparam logic       RST_OUT_SEL    = 1'h0;
	localparam logic [1:0] RST_WARMUP     = 2'h2;
	localparam logic [1:0] RST_HALT_TYPE  = 2'h3;
	localparam logic       RST_PIN_HOLD   = 1'h0;
	localparam logic [6:0] RST_NOISE      = 7'h23;
	localparam logic [3:0] RST_DBL_CTRL   = 4'h0;
	localparam logic [7:0] RST_DBL_SET    = 8'h13;
	localparam logic [7:0] PROTECT_OFF    = 8'h1F;
	localparam int         BIT_SRC_SEL    = 3;
	localparam int         BIT_OUT_SEL    = 6;
	localparam int         BIT_PIN_HOLD   = 0;
	localparam int         NZ_LATCH_EN    = 3;
	localparam int         NZ_EXT_CLK     = 2;
	localparam int         NZ_DRV_HIGH    = 1;
	localparam int         NZ_DRV_LOW     = 0;

	// ******************************************************
	// gear codes, halt codes, warm-up codes
	// ******************************************************
	localparam logic [2:0] GEAR_DIV16     = 3'h4;
	localparam logic [1:0] HALT_STOP      = 2'h1;
	localparam logic [1:0] HALT_LIGHT     = 2'h2;
	localparam logic [1:0] HALT_FULL      = 2'h3;
	localparam logic [1:0] WU_CODE_8      = 2'h1;
	localparam logic [1:0] WU_CODE_14     = 2'h2;
	localparam logic [1:0] WU_CODE_16     = 2'h3;
	localparam logic [16:0] WU_CNT_8      = 17'h00100;
	localparam int          WU_CNT_14     = 16384;
	localparam int          WU_CNT_16     = 65536;

	typedef enum logic [3:0] {
		SCM_RUN   = 4'b0001,
		SCM_STOP  = 4'b0010,
		SCM_LIGHT = 4'b0100,
		SCM_FULL  = 4'b1000
	} scm_state_t;

endpackage

/* rtl/scm_gear_div.sv */
// high-frequency clock gear divider, one tick per geared cycle
`timescale 1ns/100ps
module scm_gear_div
	import scm_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [2:0] gear_code,
	output logic            gear_tick
);

	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt;
	logic [2:0] gear_ff;
	logic [2:0] nxt_gear;
	logic       tick_ff;
	logic       nxt_tick;

	// reserved codes fall back to the slowest legal gear
	function automatic logic [2:0] legal_gear(input logic [2:0] code);
		legal_gear = (code > GEAR_DIV16) ? GEAR_DIV16 : code;
	endfunction

	function automatic logic [3:0] gear_limit(input logic [2:0] code);
		gear_limit = 4'((5'h1 << code) - 5'h1);
	endfunction

	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_gear = gear_ff;
		nxt_tick = 1'b0;
		if (cnt_ff >= gear_limit(gear_ff)) begin
			nxt_cnt  = 4'h0;
			nxt_tick = 1'b1;
			// new gear only at a wrap, so no period is ever cut short
			nxt_gear = legal_gear(gear_code);
		end else begin
			nxt_cnt = cnt_ff + 4'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt_ff  <= 4'h0;
			gear_ff <= RST_GEAR;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			gear_ff <= nxt_gear;
			tick_ff <= nxt_tick;
		end
	end

	assign gear_tick = tick_ff;

endmodule // scm_gear_div

/* testbench/testbench.sv */
// self-checking testbench for the system clock mode control block
`timescale 1ns/100ps
module testbench
	import scm_pkg::*;
;
	// ******************************************************
	// signals and design instance
	// ******************************************************
	logic       sys_clk, rst, avs_read, avs_write, low_freq_clock;
	logic [9:0] avs_address;
	logic [7:0] avs_writedata, avs_readdata;
	logic       avs_waitrequest, warmup_start, halt_req, wake_req;
	logic       cpu_clk_en, periph_clk_en, clock_output_pin, warmup_busy;
	logic       halt_pins_off, halt_pins_hold;
	logic [1:0] halt_mode;
	logic       latch_strobe_output_enable, external_clock_input_select;
	logic       high_osc_drive_strength, low_osc_drive_strength;
	logic       lf_run;
	logic [4:0] lf_cnt;
	int         n_errors, n_tests, cyc;
	int         c_cpu, c_per, c_tog, busy_cnt;
	logic [1:0] wu_codes [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
	int         wu_exp   [4] = '{256, 20, 40, 20};

	// short warm-up counts keep the run brief
	scm_clock_mode #(.WU_CYC_14(20), .WU_CYC_16(40)) u_dut (
		.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .low_freq_clock(low_freq_clock),
		.warmup_start(warmup_start), .halt_req(halt_req), .wake_req(wake_req),
		.cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
		.clock_output_pin(clock_output_pin), .warmup_busy(warmup_busy),
		.halt_pins_off(halt_pins_off), .halt_pins_hold(halt_pins_hold), .halt_mode(halt_mode),
		.latch_strobe_output_enable(latch_strobe_output_enable),
		.external_clock_input_select(external_clock_input_select),
		.high_osc_drive_strength(high_osc_drive_strength),
		.low_osc_drive_strength(low_osc_drive_strength));

	// ******************************************************
	// clock, low clock source, timeout
	// ******************************************************
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// low clock period 32 system cycles, stands still when not running
	always @(posedge sys_clk) begin
		lf_cnt <= lf_run ? lf_cnt + 5'h01 : lf_cnt;
		low_freq_clock <= lf_run ? lf_cnt[4] : low_freq_clock;
	end

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			$display("MISMATCH at %0t: timeout", $time);
			wrap_up();
		end
	end

	// ******************************************************
	// tasks
	// ******************************************************
	// no local limit: only the global timeout may end a hung access
	task automatic wait_ack();
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
	endtask

	task automatic bus_write(input logic [9:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		wait_ack();
		avs_write <= 1'b0;
	endtask

	task automatic bus_read(input logic [9:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_read <= 1'b1;
		wait_ack();
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_reg(input logic [9:0] a, input logic [7:0] exp, input string what);
		logic [7:0] d;
		bus_read(a, d);
		chk(d, exp, what);
	endtask

	task automatic chk_rng(input int got, input int lo, input int hi, input string what);
		n_tests++;
		if (got < lo || got > hi) begin
			n_errors++;
			$display("MISMATCH at %0t: %s count %0d not in %0d..%0d", $time, what, got, lo, hi);
		end
	endtask

	// counts enable pulses and output pin toggles over n cycles
	task automatic sample(input int n);
		logic prev;
		c_cpu = 0;
		c_per = 0;
		c_tog = 0;
		prev = clock_output_pin;
		repeat (n) begin
			@(posedge sys_clk);
			if (cpu_clk_en === 1'b1) c_cpu++;
			if (periph_clk_en === 1'b1) c_per++;
			if (clock_output_pin !== prev) c_tog++;
			prev = clock_output_pin;
		end
	endtask

	// one-cycle pulse: 0 warm-up start, 1 halt request, 2 wake request
	task automatic pulse(input int which);
		@(posedge sys_clk);
		case (which)
			0: warmup_start <= 1'b1;
			1: halt_req <= 1'b1;
			default: wake_req <= 1'b1;
		endcase
		@(posedge sys_clk);
		warmup_start <= 1'b0;
		halt_req <= 1'b0;
		wake_req <= 1'b0;
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ******************************************************
	// main sequence
	// ******************************************************
	initial begin
		rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 10'h000;
		avs_writedata = 8'h00; low_freq_clock = 1'b0; warmup_start = 1'b0;
		halt_req = 1'b0; wake_req = 1'b0; lf_run = 1'b0; lf_cnt = 5'h00;
		n_errors = 0; n_tests = 0; cyc = 0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		// reset values, undefined bits read 0, unmapped reads 0
		chk_reg(ADDR_SRC_GEAR, 8'h04, "src/gear reset");
		chk_reg(ADDR_OUT_HALT, 8'h2C, "out/halt reset");
		chk_reg(ADDR_NOISE, 8'h23, "noise reset");
		chk_reg(ADDR_DBL_CTRL, 8'h00, "doubler ctrl reset");
		// the second doubler register is never touched
		bus_write(ADDR_DBL_CTRL, 8'h00);
		chk_reg(ADDR_DBL_CTRL, 8'h00, "doubler ctrl after zero write");
		chk_reg(10'h3FC, 8'h00, "unmapped read");
		chk({6'h00, halt_mode}, 8'h03, "halt_mode port reset");
		$display("test reset done");

		// gear divide, geared clock on output pin
		bus_write(ADDR_OUT_HALT, 8'h6C);
		for (int g = 0; g <= 5; g++) begin
			bus_write(ADDR_SRC_GEAR, 8'hF0 | 8'(g));
			chk_reg(ADDR_SRC_GEAR, 8'(g), "gear readback");
			repeat (40) @(posedge sys_clk);
			sample(128);
			chk_rng(c_cpu, (128 >> (g > 4 ? 4 : g)) - 1, (128 >> (g > 4 ? 4 : g)) + 1, "cpu");
			chk_rng(c_tog, (128 >> (g > 4 ? 4 : g)) - 1, (128 >> (g > 4 ? 4 : g)) + 1, "out");
		end
		$display("test gear done");

		// low clock as system clock and as output clock
		lf_run <= 1'b1;
		bus_write(ADDR_OUT_HALT, 8'h2C);
		bus_write(ADDR_SRC_GEAR, 8'h08);
		repeat (80) @(posedge sys_clk);
		sample(256);
		chk_rng(c_cpu, 7, 9, "cpu on low clock");
		chk_rng(c_tog, 7, 9, "out on low clock");
		// switching back waits for a low clock tick, so it must still run
		bus_write(ADDR_SRC_GEAR, 8'h00);
		repeat (48) @(posedge sys_clk);
		sample(32);
		chk_rng(c_cpu, 31, 32, "cpu back on high clock");
		lf_run <= 1'b0;
		repeat (10) @(posedge sys_clk);
		sample(64);
		chk_rng(c_tog, 0, 0, "out with low clock still");
		$display("test source done");

		// warm-up counts for every code, drive strength normal first
		chk({6'h00, high_osc_drive_strength, low_osc_drive_strength}, 8'h03, "drive");
		for (int i = 0; i < 4; i++) begin
			bus_write(ADDR_OUT_HALT, {2'h0, wu_codes[i], 4'hC});
			pulse(0);
			busy_cnt = 0;
			repeat (300) begin
				@(posedge sys_clk);
				if (warmup_busy === 1'b1) busy_cnt++;
			end
			chk_rng(busy_cnt, wu_exp[i], wu_exp[i], "warm-up");
		end
		$display("test warmup done");

		// halt types with pin hold off and on
		for (int h = 0; h < 4; h++) begin
			for (int p = 0; p < 2; p++) begin
				bus_write(ADDR_OUT_HALT, {4'h2, 2'(h), 1'b0, 1'(p)});
				pulse(1);
				repeat (3) @(posedge sys_clk);
				chk({6'h00, halt_mode}, 8'(h), "halt_mode");
				chk({7'h00, halt_pins_off}, 8'((h == 1 || h == 2) && p == 0), "pins off");
				chk({7'h00, halt_pins_hold}, 8'((h == 1 || h == 2) && p == 1), "pins hold");
				sample(16);
				chk_rng(c_cpu, h == 0 ? 16 : 0, h == 0 ? 16 : 0, "cpu in halt");
				chk_rng(c_per, (h == 0 || h == 3) ? 16 : 0, (h == 0 || h == 3) ? 16 : 0, "per");
				pulse(2);
				repeat (3) @(posedge sys_clk);
				chk({6'h00, halt_pins_off, halt_pins_hold}, 8'h00, "pins after wake");
			end
		end
		$display("test halt done");

		// noise bits to ports, protection on and off
		bus_write(ADDR_NOISE, 8'h0C);
		// the write lands at the acknowledging edge, ports show it one edge on
		@(posedge sys_clk);
		chk({4'h0, latch_strobe_output_enable, external_clock_input_select,
			high_osc_drive_strength, low_osc_drive_strength}, 8'h0C, "noise ports");
		bus_write(ADDR_NOISE, 8'h23);
		bus_write(ADDR_PROTECT, 8'h00);
		chk_reg(ADDR_NOISE, 8'hA3, "protect flag on");
		chk_reg(ADDR_PROTECT, 8'h00, "protect reg reads 0");
		bus_write(ADDR_SRC_GEAR, 8'h03);
		chk_reg(ADDR_SRC_GEAR, 8'h00, "write dropped");
		bus_write(ADDR_PROTECT, 8'h1E);
		chk_reg(ADDR_NOISE, 8'hA3, "1E keeps protect");
		bus_write(ADDR_PROTECT, 8'h1F);
		chk_reg(ADDR_NOISE, 8'h23, "protect flag off");
		bus_write(ADDR_SRC_GEAR, 8'h03);
		chk_reg(ADDR_SRC_GEAR, 8'h03, "write restored");
		bus_write(ADDR_PROTECT, 8'hFF);
		chk_reg(ADDR_NOISE, 8'hA3, "FF turns protect on");
		$display("test protect done");
		wrap_up();
	end

endmodule // testbench
